// ### design/bcl_regs.svh
// Purpose: constants for the breaker command and led target block
// Assumes: 40 MHz clk_in
// Notes: times kept in ms, cycle counts derived where used
`ifndef BCL_REGS_SVH
`define BCL_REGS_SVH

`define BCL_CLK_KHZ 40000
`define BCL_MIN_OPEN_MS 100
`define BCL_RUN_A_MS 2
`define BCL_RUN_B_MS 10
`define BCL_RUN_C_MS 20
`define BCL_BLINK_MS 250
`define BCL_NUM_LEDS 16
`define BCL_OR_W 8
`define BCL_NUM_BTN 7
`define BCL_NUM_AUX 6
`define BCL_NUM_SECT 8
`define BCL_SRC_BUTTON 0
`define BCL_SRC_COMMS 1
`define BCL_SRC_INPUT 2

`endif

// ### design/bcl_pkg.sv
// Purpose: types shared by the breaker command block
// Assumes: nothing
// Notes: panel states gray coded along idle-select-arm-exec
package bcl_pkg;
   typedef enum logic [1:0] {
      BCL_IDLE = 2'h0,
      BCL_SEL = 2'h1,
      BCL_ARM = 2'h3,
      BCL_EXEC = 2'h2
   } bcl_panel_e;

   typedef enum logic [1:0] {
      BCL_CYC_2MS = 2'h0,
      BCL_CYC_10MS = 2'h1,
      BCL_CYC_20MS = 2'h2,
      BCL_CYC_OFF = 2'h3
   } bcl_cycle_e;

   typedef logic [15:0] bcl_ms_t;
endpackage

// ### design/bcl_fail_timer.sv
// Purpose: command failure supervision for one command type
// Assumes: ms_tick_in is a one-cycle pulse every millisecond
// Notes: flag stays until the next command of this type
`timescale 1ns/100ps
`default_nettype none
module bcl_fail_timer (
   input wire logic clk_in,                  // clock
   input wire logic resetn_in,               // async reset, low
   input wire logic ce_in,                   // clock enable
   input wire logic ms_tick_in,              // 1 ms pulse
   input wire logic start_in,                // command issued
   input wire logic stop_in,                 // breaker changed state
   input wire bcl_pkg::bcl_ms_t limit_in,    // failure time in ms
   output logic fail_out                     // command failure flag
);
   logic run_q;
   bcl_pkg::bcl_ms_t cnt_q;
   logic expire;

   assign expire = run_q && ms_tick_in && (cnt_q + 16'h0001 >= limit_in);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         run_q <= 1'b0;
         cnt_q <= 16'h0000;
      end else if (ce_in) begin
         if (start_in) begin
            run_q <= 1'b1;
            cnt_q <= 16'h0000;
         end else if (stop_in || expire) begin
            run_q <= 1'b0;
         end else if (run_q && ms_tick_in) begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fail_out <= 1'b0;
      end else if (ce_in) begin
         if (expire) begin
            fail_out <= 1'b1;
         end else if (start_in) begin
            fail_out <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### design/bcl_led_cell.sv
// Purpose: one user led target cell
// Assumes: inputs already chosen from the signal set
// Notes: latch lives in flops only, so power loss clears it
`timescale 1ns/100ps
`default_nettype none
module bcl_led_cell (
   input wire logic clk_in,        // clock
   input wire logic resetn_in,     // async reset, low
   input wire logic ce_in,         // clock enable
   input wire logic [7:0] or_in,   // or block inputs
   input wire logic [7:0] or_en_in, // or input selects
   input wire logic single_in,     // single block input
   input wire logic and_mode_in,   // 1 joins blocks by and
   input wire logic latch_en_in,   // led is latched
   input wire logic clear_in,      // led latch clear pulse
   input wire logic lamp_in,       // force on
   output logic led_out            // led drive
);
   logic grp;
   logic comb;
   logic latch_q;

   assign grp = |(or_in & or_en_in);
   assign comb = and_mode_in ? (grp & single_in) : (grp | single_in);

   // set wins over clear so a live event is never lost
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         latch_q <= 1'b0;
      end else if (ce_in) begin
         latch_q <= latch_en_in & ((latch_q & ~clear_in) | comb);
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         led_out <= 1'b0;
      end else if (ce_in) begin
         led_out <= lamp_in | comb | latch_q;
      end
   end
endmodule
`default_nettype wire

// ### design/bcl_breaker_cmd.sv
// Purpose: breaker open/close contacts, failure supervision, led targets
// Assumes: all inputs synchronous to clk_in; panel keys are one-cycle presses
// Notes: long counts are parameters so simulation can shorten them
`include "bcl_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module bcl_breaker_cmd #(
   parameter int MS_CYC = `BCL_CLK_KHZ,
   parameter int MIN_OPEN_CYC = `BCL_MIN_OPEN_MS * `BCL_CLK_KHZ
) (
   input wire logic clk_in,                   // 40 MHz clock
   input wire logic resetn_in,                // async reset, low
   input wire logic ce_in,                    // clock enable
   input wire logic prot_trip_in,             // protection trip
   input wire logic prot_pickup_in,           // protection pickup
   input wire logic trip_block_in,            // trip blocking control
   input wire logic recl_close_in,            // recloser close command
   input wire logic remote_open_in,           // manual open, comms
   input wire logic remote_close_in,          // manual close, comms
   input wire logic breaker_closed_in,        // breaker position
   input wire bcl_pkg::bcl_ms_t open_fail_ms_in,  // open failure time
   input wire bcl_pkg::bcl_ms_t close_fail_ms_in, // close failure time
   input wire logic key_breaker_in,           // breaker select key
   input wire logic [5:0] user_button_in,     // user_button_first..sixth
   input wire logic key_close_in,             // close key
   input wire logic key_open_in,              // open key
   input wire logic key_confirm_in,           // confirm key
   input wire logic key_cancel_in,            // cancel key
   input wire logic [5:0] elem_state_in,      // user element states
   input wire logic [6:0] colour_red_in,      // red when element on
   input wire logic [127:0] led_or_in,        // or inputs, 8 per led
   input wire logic [127:0] led_or_en_in,     // or input selects
   input wire logic [15:0] led_single_in,     // single inputs
   input wire logic [15:0] led_and_mode_in,   // and join per led
   input wire logic [15:0] led_latch_in,      // latched per led
   input wire logic [2:0] clr_src_en_in,      // clear source enables
   input wire logic clr_button_in,            // clear from button
   input wire logic clr_comms_in,             // clear from comms
   input wire logic indicator_clear_input_in, // clear digital input
   input wire logic clr_menu_in,              // clear menu command
   input wire logic indicator_clear_key_in,   // clear key held
   input wire logic reset_screen_in,          // clear screen shown
   input wire logic ready_in,                 // device ready
   input wire logic [15:0] sect_prio_in,      // 2-bit cycle per section
   output logic open_contact_one_out,         // open contact 1
   output logic open_contact_two_out,         // open contact 2
   output logic close_contact_one_out,        // close contact 1
   output logic close_contact_two_out,        // close contact 2
   output logic trip_flag_out,                // internal trip
   output logic masked_trip_out,              // masked trip
   output logic prot_reset_out,               // reset protection pulse
   output logic open_fail_out,                // open command failure
   output logic close_fail_out,               // close command failure
   output logic [5:0] aux_contact_out,        // aux_contact_first..sixth
   output logic [15:0] led_out,               // user leds
   output logic [6:0] btn_red_out,            // button leds red
   output logic [6:0] btn_green_out,          // button leds green
   output logic ready_led_out,                // ready indicator
   output logic [7:0] sect_run_out            // section run strobes
);
   // ---------------------------------------------------------------
   // millisecond time base and run cycles
   // ---------------------------------------------------------------
   localparam logic [4:0] RUN_A = 5'(`BCL_RUN_A_MS);
   localparam logic [4:0] RUN_B = 5'(`BCL_RUN_B_MS);
   localparam logic [4:0] RUN_C = 5'(`BCL_RUN_C_MS);
   localparam logic [8:0] BLINK = 9'(`BCL_BLINK_MS);

   function automatic logic [4:0] cyc_next(input logic [4:0] cnt, input logic [4:0] per);
      cyc_next = (cnt == per - 5'h01) ? 5'h00 : cnt + 5'h01;
   endfunction

   function automatic logic cyc_hit(input logic [4:0] cnt, input logic [4:0] per);
      cyc_hit = (cnt == per - 5'h01);
   endfunction

   logic [15:0] ms_cnt_q;
   logic ms_tick;
   logic [4:0] cyc_a_q;
   logic [4:0] cyc_b_q;
   logic [4:0] cyc_c_q;
   logic [3:0] run_hit;

   assign ms_tick = (ms_cnt_q == 16'(MS_CYC - 1));
   assign run_hit = {1'b0, ms_tick & cyc_hit(cyc_c_q, RUN_C),
                     ms_tick & cyc_hit(cyc_b_q, RUN_B), ms_tick & cyc_hit(cyc_a_q, RUN_A)};

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ms_cnt_q <= 16'h0000;
      end else if (ce_in) begin
         ms_cnt_q <= ms_tick ? 16'h0000 : ms_cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cyc_a_q <= 5'h00;
         cyc_b_q <= 5'h00;
         cyc_c_q <= 5'h00;
      end else if (ce_in && ms_tick) begin
         cyc_a_q <= cyc_next(cyc_a_q, RUN_A);
         cyc_b_q <= cyc_next(cyc_b_q, RUN_B);
         cyc_c_q <= cyc_next(cyc_c_q, RUN_C);
      end
   end

   // each section takes exactly one cycle; code 3 parks it
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sect_run_out <= 8'h00;
      end else if (ce_in) begin
         for (int i = 0; i < `BCL_NUM_SECT; i++) begin
            sect_run_out[i] <= run_hit[sect_prio_in[2*i +: 2]];
         end
      end
   end

   // ---------------------------------------------------------------
   // front panel selection and confirmation
   // ---------------------------------------------------------------
   bcl_pkg::bcl_panel_e pnl_q;
   logic [2:0] sel_q;
   logic cmd_close_q;
   logic man_open_q;
   logic man_close_q;
   logic any_user;
   logic [2:0] user_idx;

   assign any_user = |user_button_in;

   always_comb begin
      user_idx = 3'h1;
      for (int i = 5; i >= 0; i--) begin
         if (user_button_in[i]) begin
            user_idx = 3'(i + 1);
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pnl_q <= bcl_pkg::BCL_IDLE;
         sel_q <= 3'h0;
         cmd_close_q <= 1'b0;
      end else if (ce_in) begin
         case (pnl_q)
            bcl_pkg::BCL_IDLE: begin
               if (key_breaker_in) begin
                  sel_q <= 3'h0;
                  pnl_q <= bcl_pkg::BCL_SEL;
               end else if (any_user) begin
                  sel_q <= user_idx;
                  pnl_q <= bcl_pkg::BCL_SEL;
               end
            end
            bcl_pkg::BCL_SEL: begin
               if (key_cancel_in) begin
                  pnl_q <= bcl_pkg::BCL_IDLE;
               end else if (key_close_in || key_open_in) begin
                  cmd_close_q <= key_close_in;
                  pnl_q <= bcl_pkg::BCL_ARM;
               end
            end
            bcl_pkg::BCL_ARM: begin
               // nothing moves until the operator confirms
               if (key_cancel_in) begin
                  pnl_q <= bcl_pkg::BCL_IDLE;
               end else if (key_confirm_in) begin
                  pnl_q <= bcl_pkg::BCL_EXEC;
               end
            end
            bcl_pkg::BCL_EXEC: begin
               pnl_q <= bcl_pkg::BCL_IDLE;
            end
            default: begin
               pnl_q <= bcl_pkg::BCL_IDLE;
            end
         endcase
      end
   end

   // manual commands are one-cycle pulses; the contact logic stretches them
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         man_open_q <= 1'b0;
         man_close_q <= 1'b0;
      end else if (ce_in) begin
         man_open_q <= (pnl_q == bcl_pkg::BCL_EXEC) && (sel_q == 3'h0)
                       && !cmd_close_q && breaker_closed_in;
         man_close_q <= (pnl_q == bcl_pkg::BCL_EXEC) && (sel_q == 3'h0)
                        && cmd_close_q && !breaker_closed_in;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         aux_contact_out <= 6'h00;
      end else if (ce_in && pnl_q == bcl_pkg::BCL_EXEC && sel_q != 3'h0) begin
         aux_contact_out[sel_q - 3'h1] <= cmd_close_q;
      end
   end

   // ---------------------------------------------------------------
   // open logic, trip blocking and minimum pulse
   // ---------------------------------------------------------------
   logic open_req;
   logic close_req;
   logic block_q;
   logic block_rise;
   logic open_act_q;
   logic close_act_q;
   logic [22:0] open_cnt_q;
   logic [22:0] close_cnt_q;
   logic kill;

   assign open_req = prot_trip_in | man_open_q | remote_open_in;
   assign close_req = recl_close_in | man_close_q | remote_close_in;
   assign block_rise = trip_block_in & ~block_q;
   assign kill = block_rise & (open_act_q | trip_flag_out);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         block_q <= 1'b0;
         prot_reset_out <= 1'b0;
      end else if (ce_in) begin
         block_q <= trip_block_in;
         prot_reset_out <= kill;
      end
   end

   // flags follow the trip even when the contacts are blocked
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         trip_flag_out <= 1'b0;
         masked_trip_out <= 1'b0;
      end else if (ce_in) begin
         trip_flag_out <= prot_trip_in & ~kill;
         masked_trip_out <= prot_trip_in & ~kill
                            & (trip_block_in | prot_pickup_in);
      end
   end

   // blocking wins over the minimum pulse
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         open_act_q <= 1'b0;
         open_cnt_q <= 23'h00_0000;
      end else if (ce_in) begin
         if (trip_block_in) begin
            open_act_q <= 1'b0;
            open_cnt_q <= 23'h00_0000;
         end else if (open_req) begin
            open_act_q <= 1'b1;
            open_cnt_q <= 23'(MIN_OPEN_CYC - 1);
         end else if (open_cnt_q != 23'h00_0000) begin
            open_cnt_q <= open_cnt_q - 23'h00_0001;
         end else begin
            open_act_q <= 1'b0;
         end
      end
   end

   // close gets the same stretch so a manual pulse closes reliably
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         close_act_q <= 1'b0;
         close_cnt_q <= 23'h00_0000;
      end else if (ce_in) begin
         if (open_act_q || open_req) begin
            close_act_q <= 1'b0;
            close_cnt_q <= 23'h00_0000;
         end else if (close_req) begin
            close_act_q <= 1'b1;
            close_cnt_q <= 23'(MIN_OPEN_CYC - 1);
         end else if (close_cnt_q != 23'h00_0000) begin
            close_cnt_q <= close_cnt_q - 23'h00_0001;
         end else begin
            close_act_q <= 1'b0;
         end
      end
   end

   assign open_contact_one_out = open_act_q;
   assign open_contact_two_out = open_act_q;
   assign close_contact_one_out = close_act_q;
   assign close_contact_two_out = close_act_q;

   // ---------------------------------------------------------------
   // command failure supervision
   // ---------------------------------------------------------------
   logic brk_q;
   logic open_prev_q;
   logic close_prev_q;
   logic brk_change;

   assign brk_change = breaker_closed_in ^ brk_q;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         brk_q <= 1'b0;
         open_prev_q <= 1'b0;
         close_prev_q <= 1'b0;
      end else if (ce_in) begin
         brk_q <= breaker_closed_in;
         open_prev_q <= open_req & ~trip_block_in;
         close_prev_q <= close_req;
      end
   end

   bcl_fail_timer u_open_fail (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .ce_in(ce_in),
      .ms_tick_in(ms_tick),
      .start_in(open_req & ~trip_block_in & ~open_prev_q),
      .stop_in(brk_change),
      .limit_in(open_fail_ms_in),
      .fail_out(open_fail_out)
   );

   bcl_fail_timer u_close_fail (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .ce_in(ce_in),
      .ms_tick_in(ms_tick),
      .start_in(close_req & ~close_prev_q),
      .stop_in(brk_change),
      .limit_in(close_fail_ms_in),
      .fail_out(close_fail_out)
   );

   // ---------------------------------------------------------------
   // led targets, clear and lamp test
   // ---------------------------------------------------------------
   logic lamp;
   logic lamp_q;
   logic led_clear;

   assign lamp = indicator_clear_key_in & reset_screen_in;
   assign led_clear = clr_menu_in
                      | (clr_src_en_in[`BCL_SRC_BUTTON] & clr_button_in)
                      | (clr_src_en_in[`BCL_SRC_COMMS] & clr_comms_in)
                      | (clr_src_en_in[`BCL_SRC_INPUT] & indicator_clear_input_in)
                      | (lamp_q & ~lamp);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         lamp_q <= 1'b0;
      end else if (ce_in) begin
         lamp_q <= lamp;
      end
   end

   for (genvar g = 0; g < `BCL_NUM_LEDS; g++) begin : g_led
      bcl_led_cell u_cell (
         .clk_in(clk_in),
         .resetn_in(resetn_in),
         .ce_in(ce_in),
         .or_in(led_or_in[g*`BCL_OR_W +: `BCL_OR_W]),
         .or_en_in(led_or_en_in[g*`BCL_OR_W +: `BCL_OR_W]),
         .single_in(led_single_in[g]),
         .and_mode_in(led_and_mode_in[g]),
         .latch_en_in(led_latch_in[g]),
         .clear_in(led_clear),
         .lamp_in(lamp),
         .led_out(led_out[g])
      );
   end

   // ready lamp bypasses the cells entirely
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ready_led_out <= 1'b0;
      end else if (ce_in) begin
         ready_led_out <= ready_in | lamp;
      end
   end

   // ---------------------------------------------------------------
   // button leds
   // ---------------------------------------------------------------
   logic [8:0] blink_cnt_q;
   logic blink_q;
   logic [6:0] elem_on;

   assign elem_on = {elem_state_in, breaker_closed_in};

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         blink_cnt_q <= 9'h000;
         blink_q <= 1'b0;
      end else if (ce_in && ms_tick) begin
         if (blink_cnt_q == BLINK - 9'h001) begin
            blink_cnt_q <= 9'h000;
            blink_q <= ~blink_q;
         end else begin
            blink_cnt_q <= blink_cnt_q + 9'h001;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         btn_red_out <= 7'h00;
         btn_green_out <= 7'h00;
      end else if (ce_in) begin
         for (int i = 0; i < `BCL_NUM_BTN; i++) begin
            if (lamp) begin
               btn_red_out[i] <= 1'b1;
               btn_green_out[i] <= 1'b1;
            end else if (pnl_q != bcl_pkg::BCL_IDLE && sel_q == 3'(i) && blink_q) begin
               btn_red_out[i] <= 1'b0;
               btn_green_out[i] <= 1'b0;
            end else begin
               btn_red_out[i] <= ~(elem_on[i] ^ colour_red_in[i]);
               btn_green_out[i] <= elem_on[i] ^ colour_red_in[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### test/bcl_asserts.sv
// Purpose: port checks for bcl_breaker_cmd
// Assumes: ce_in held high by the bench
// Notes: open width measured by a helper counter
`timescale 1ns/100ps
`default_nettype none
module bcl_asserts #(parameter int MIN_OPEN_CYC = 20) (
   input wire logic clk_in, resetn_in, prot_trip_in, prot_pickup_in, trip_block_in, // controls
   input wire logic indicator_clear_key_in, reset_screen_in, // lamp test keys
   input wire logic open_contact_one_out, open_contact_two_out, close_contact_one_out, // contacts
   input wire logic close_contact_two_out, trip_flag_out, masked_trip_out, prot_reset_out, // flags
   input wire logic close_fail_out, // close failure
   input wire logic [15:0] led_out // user leds
);
   int hi_q;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // cycles the open pair has stood high, zero while low
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) hi_q <= 0;
      else hi_q <= open_contact_one_out ? hi_q + 1 : 0;
   end
   open_pair_a: assert property (open_contact_one_out == open_contact_two_out)
      else $error("open pair differs");
   close_pair_a: assert property (close_contact_one_out == close_contact_two_out)
      else $error("close pair differs");
   trip_open_a: assert property (prot_trip_in && !trip_block_in |=> open_contact_one_out)
      else $error("trip did not open");
   block_open_a: assert property (trip_block_in |=> !open_contact_one_out)
      else $error("open while blocked");
   hold_open_a: assert property ($fell(open_contact_one_out) && !$past(trip_block_in) |-> hi_q >= MIN_OPEN_CYC)
      else $error("open pulse too short");
   masked_set_a: assert property (prot_trip_in && (trip_block_in || prot_pickup_in) && !$rose(trip_block_in)
      |=> masked_trip_out && trip_flag_out) else $error("masked trip missing");
   prot_reset_a: assert property ($rose(trip_block_in) && (open_contact_one_out || trip_flag_out)
      |=> prot_reset_out ##1 !prot_reset_out) else $error("no reset pulse");
   lamp_test_a: assert property (indicator_clear_key_in && reset_screen_in |=> &led_out)
      else $error("lamp test dark");
   cover property (close_fail_out);
   cover property (prot_reset_out);
   cover property (masked_trip_out);
endmodule
bind bcl_breaker_cmd bcl_asserts #(.MIN_OPEN_CYC(MIN_OPEN_CYC)) u_asserts (.*);
`default_nettype wire

// ### test/bcl_breaker_model.sv
// Purpose: breaker that follows the command contacts
// Assumes: starts closed
// Notes: stuck_in freezes it so failure timers can run out
`timescale 1ns/100ps
`default_nettype none
module bcl_breaker_model #(parameter int DLY = 2) (
   input wire logic clk_in, resetn_in, open_cmd_in, close_cmd_in, stuck_in, // commands
   output logic closed_out // breaker position
);
   int d_q;
   // a command must stand DLY+1 cycles before the mechanism moves
   wire move = !stuck_in && (closed_out ? open_cmd_in : close_cmd_in);
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) d_q <= 0;
      else d_q <= (!move || d_q == DLY) ? 0 : d_q + 1;
   end
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) closed_out <= 1'h1;
      else if (move && d_q == DLY) closed_out <= !closed_out;
   end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Purpose: self-checking bench for bcl_breaker_cmd
// Assumes: ms tick shortened to 10 cycles, stretch to 20
// Notes: failure limits set to 3 ms
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk_in, resetn_in, ce_in, prot_trip_in, prot_pickup_in, trip_block_in, recl_close_in, stuck, ready_in;
   logic remote_open_in, remote_close_in, key_breaker_in, key_close_in, key_open_in, key_confirm_in, key_cancel_in;
   logic clr_button_in, clr_comms_in, indicator_clear_input_in, clr_menu_in, indicator_clear_key_in, reset_screen_in;
   logic open_contact_one_out, open_contact_two_out, close_contact_one_out, close_contact_two_out, ready_led_out;
   logic trip_flag_out, masked_trip_out, prot_reset_out, open_fail_out, close_fail_out;
   logic [5:0] user_button_in, elem_state_in, aux_contact_out;
   logic [6:0] colour_red_in, btn_red_out, btn_green_out;
   logic [127:0] led_or_in, led_or_en_in;
   logic [15:0] led_single_in, led_and_mode_in, led_latch_in, sect_prio_in, led_out;
   logic [7:0] sect_run_out;
   logic [2:0] clr_src_en_in;
   bcl_pkg::bcl_ms_t open_fail_ms_in, close_fail_ms_in;
   wire breaker_closed_in;
   int miscompares, n_tests;
   bcl_breaker_cmd #(.MS_CYC(10), .MIN_OPEN_CYC(20)) dut (.*);
   bcl_breaker_model u_brk (.clk_in(clk_in), .resetn_in(resetn_in), .open_cmd_in(open_contact_one_out),
      .close_cmd_in(close_contact_one_out), .stuck_in(stuck), .closed_out(breaker_closed_in));
   task cyc(input int n);
      repeat (n) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task panel(input logic cl);
      @(posedge clk_in) key_breaker_in <= 1'h1;
      @(posedge clk_in) key_breaker_in <= 1'h0;
      {key_close_in, key_open_in} <= {cl, !cl};
      @(posedge clk_in) {key_close_in, key_open_in, key_confirm_in} <= 3'h1;
      @(posedge clk_in) key_confirm_in <= 1'h0;
      cyc(3);
   endtask
   task stop_test;
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      clk_in = 1'h0;
      forever #12.5 clk_in = ~clk_in;
   end
   initial begin
      repeat (3000) @(posedge clk_in);
      miscompares++;
      stop_test();
   end
   initial begin
      {prot_trip_in, prot_pickup_in, trip_block_in, recl_close_in, remote_open_in, remote_close_in, key_breaker_in,
         key_close_in, key_open_in, key_confirm_in, key_cancel_in, clr_button_in, clr_comms_in, clr_menu_in,
         indicator_clear_input_in, indicator_clear_key_in, reset_screen_in, user_button_in, elem_state_in,
         colour_red_in, led_or_in, led_single_in, sect_prio_in, clr_src_en_in, stuck, resetn_in} = '0;
      {ce_in, ready_in, open_fail_ms_in, close_fail_ms_in} = {2'h3, 16'h0003, 16'h0003};
      {led_or_en_in, led_latch_in, led_and_mode_in} = {128'h101, 16'h0001, 16'h0002};
      repeat (20) @(posedge clk_in);
      resetn_in <= 1'h1;
      @(posedge clk_in) prot_trip_in <= 1'h1;
      @(posedge clk_in) prot_trip_in <= 1'h0;
      cyc(0);
      chk({open_contact_one_out, trip_flag_out}, 2'h3);
      cyc(15);
      chk(open_contact_one_out, 1'h1);
      cyc(40);
      chk({open_contact_one_out, open_fail_out, breaker_closed_in}, 3'h0);
      @(posedge clk_in) recl_close_in <= 1'h1;
      @(posedge clk_in) recl_close_in <= 1'h0;
      cyc(0);
      chk(close_contact_one_out, 1'h1);
      cyc(40);
      chk({close_contact_one_out, close_fail_out, breaker_closed_in}, 3'h1);
      @(posedge clk_in) trip_block_in <= 1'h1;
      @(posedge clk_in) prot_trip_in <= 1'h1;
      @(posedge clk_in) prot_trip_in <= 1'h0;
      cyc(0);
      chk({open_contact_one_out, trip_flag_out, masked_trip_out}, 3'h3);
      @(posedge clk_in) {trip_block_in, prot_trip_in} <= 2'h1;
      cyc(6);
      @(posedge clk_in) {trip_block_in, prot_trip_in} <= 2'h2;
      cyc(2);
      chk({open_contact_one_out, trip_flag_out}, 2'h0);
      @(posedge clk_in) {trip_block_in, stuck, remote_close_in} <= 3'h3;
      @(posedge clk_in) remote_close_in <= 1'h0;
      cyc(50);
      chk({close_fail_out, breaker_closed_in}, 2'h2);
      $display("contacts test done");
      @(posedge clk_in) stuck <= 1'h0;
      panel(1'h1);
      chk({close_contact_one_out, close_fail_out}, 2'h2);
      cyc(40);
      panel(1'h1);
      chk(close_contact_one_out, 1'h0);
      $display("panel test done");
      @(posedge clk_in) {stuck, remote_open_in} <= 2'h3;
      @(posedge clk_in) remote_open_in <= 1'h0;
      cyc(50);
      chk(open_fail_out, 1'h1);
      @(posedge clk_in) led_or_in <= 128'h101;
      @(posedge clk_in) led_or_in <= 128'h0;
      cyc(2);
      chk(led_out[1:0], 2'h1);
      @(posedge clk_in) clr_menu_in <= 1'h1;
      @(posedge clk_in) clr_menu_in <= 1'h0;
      cyc(2);
      chk(led_out, 16'h0);
      @(posedge clk_in) {indicator_clear_key_in, reset_screen_in} <= 2'h3;
      cyc(2);
      chk({led_out, ready_led_out, btn_red_out, btn_green_out}, 31'h7fff_ffff);
      @(posedge clk_in) {indicator_clear_key_in, reset_screen_in} <= 2'h0;
      cyc(2);
      chk({led_out, ready_led_out, btn_red_out, btn_green_out}, {17'h1, 7'h7e, 7'h01});
      $display("led test done");
      stop_test();
   end
endmodule
`default_nettype wire
